// file: logic/pin_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter       WIDTH    = 1,
    parameter [3:0] INIT_VAL = 4'h0
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q  <= INIT_VAL[WIDTH-1:0];
            pin_out <= INIT_VAL[WIDTH-1:0];
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: logic/range_guard.v
// Decodes top/bottom and block protect code into a sector hit
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.vh"
module range_guard (
    input  wire                    top_bottom,
    input  wire [3:0]              block_protect_field,
    input  wire [`SECTOR_BITS-1:0] sector,
    output reg                     hit
);
    reg [`SECTOR_BITS:0] span;
    reg [`SECTOR_BITS:0] limit;

    always @* begin
        span  = {(`SECTOR_BITS+1){1'b0}};
        limit = {(`SECTOR_BITS+1){1'b0}};
        hit   = 1'b0;
        if (block_protect_field >= `PROT_ALL_CODE) begin
            hit = 1'b1;
        end else if (block_protect_field != 4'h0) begin
            span = {{`SECTOR_BITS{1'b0}}, 1'b1}
                   << (block_protect_field - 4'h1);
            if (top_bottom) begin
                hit = {1'b0, sector} < span;
            end else begin
                limit = (11'h400 - span);
                hit   = {1'b0, sector} >= limit;
            end
        end
    end
endmodule
`default_nettype wire

// file: logic/status_protect_consts.vh
// Constants for the status register and block protection of one flash die
`ifndef STATUS_PROTECT_CONSTS_VH
`define STATUS_PROTECT_CONSTS_VH

`define SR_BUSY_BIT      0
`define SR_WEL_BIT       1
`define SR_TB_BIT        5
`define SR_PROT_MSB_BIT  6
`define SR_SRWD_BIT      7
`define SR_NV_MASK       8'hFC
`define SR_RESET         8'h00

`define SECTOR_BITS      10
`define ADDR_BITS        26
`define PROT_ALL_CODE    4'hB

`define OP_WRSR          8'h01
`define OP_PROG          8'h02
`define OP_RDSR          8'h05
`define OP_WRDI          8'h04
`define OP_WREN          8'h06
`define OP_SECT_ERASE    8'hD8
`define OP_DIE_ERASE     8'hC4

`define ACMD_PROG        2'h1
`define ACMD_SECT_ERASE  2'h2
`define ACMD_DIE_ERASE   2'h3

`define CLK_PERIOD_NS    50
`define T_WRSR_NS        2000
`define T_PROG_NS        4000
`define T_SECT_ERASE_NS  20000
`define T_DIE_ERASE_NS   80000
`define NS_TO_CYC(t)     (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: logic/status_protect_core.v
// Status register, write protection and serial command front end of one die
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.vh"
module status_protect_core #(
    parameter WRSR_CYC  = `NS_TO_CYC(`T_WRSR_NS),
    parameter PROG_CYC  = `NS_TO_CYC(`T_PROG_NS),
    parameter SERA_CYC  = `NS_TO_CYC(`T_SECT_ERASE_NS),
    parameter DERA_CYC  = `NS_TO_CYC(`T_DIE_ERASE_NS)
) (
    input  wire                  clk,
    input  wire                  rst_b,
    input  wire                  sclk,
    input  wire                  cs_b,
    input  wire                  mosi,
    input  wire                  wp_b,
    output reg                   miso,
    output reg                   miso_oe,
    output reg  [7:0]            status,
    output reg                   flag_ready,
    output reg                   array_req,
    output reg  [1:0]            array_cmd,
    output reg  [`ADDR_BITS-1:0] array_addr,
    output reg                   prot_err
);
    localparam [4:0] S_OP   = 5'h01;
    localparam [4:0] S_ADDR = 5'h02;
    localparam [4:0] S_DATA = 5'h04;
    localparam [4:0] S_RD   = 5'h08;
    localparam [4:0] S_IGN  = 5'h10;

    wire [3:0]  pins_s;
    wire        sclk_s;
    wire        cs_s;
    wire        mosi_s;
    wire        wp_s;
    wire        sect_hit;
    wire [3:0]  prot_code;
    wire        hw_locked;
    wire        sclk_rise;
    wire        sclk_fall;
    wire        cs_rise;
    wire        byte_done;
    wire [7:0]  byte_in;

    reg         sclk_d_q;
    reg         cs_d_q;
    reg [4:0]   state_q;
    reg [2:0]   bit_cnt_q;
    reg [1:0]   addr_cnt_q;
    reg [6:0]   shift_q;
    reg [7:0]   tx_q;
    reg [7:0]   cmd_q;
    reg [7:0]   wdata_q;
    reg         got_data_q;
    reg [31:0]  addr_q;
    reg [15:0]  busy_cnt_q;

    pin_sync #(
        .WIDTH    (4),
        .INIT_VAL (4'hA)
    ) u_sync (
        .clk     (clk),
        .rst_b   (rst_b),
        .pin_in  ({wp_b, mosi, cs_b, sclk}),
        .pin_out (pins_s)
    );

    assign sclk_s = pins_s[0];
    assign cs_s   = pins_s[1];
    assign mosi_s = pins_s[2];
    assign wp_s   = pins_s[3];

    assign prot_code = {status[`SR_PROT_MSB_BIT], status[4:2]};

    range_guard u_guard (
        .top_bottom          (status[`SR_TB_BIT]),
        .block_protect_field (prot_code),
        .sector              (addr_q[`ADDR_BITS-1:16]),
        .hit                 (sect_hit)
    );

    // Pin low and disable bit set; dropping bit 7 needs a write, which
    // this same term blocks, so only the pin or a reset can release it
    assign hw_locked = status[`SR_SRWD_BIT] & ~wp_s;

    assign sclk_rise = sclk_s & ~sclk_d_q & ~cs_s;
    assign sclk_fall = ~sclk_s & sclk_d_q & ~cs_s;
    assign cs_rise   = cs_s & ~cs_d_q;
    assign byte_done = sclk_rise & (bit_cnt_q == 3'h7);
    assign byte_in   = {shift_q, mosi_s};

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_d_q <= 1'b0;
            cs_d_q   <= 1'b1;
        end else begin
            sclk_d_q <= sclk_s;
            cs_d_q   <= cs_s;
        end
    end

    // Serial framing: bytes sampled on rising link clock, mode 0
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= S_OP;
            bit_cnt_q  <= 3'h0;
            addr_cnt_q <= 2'h0;
            shift_q    <= 7'h00;
            tx_q       <= 8'h00;
            cmd_q      <= 8'h00;
            wdata_q    <= 8'h00;
            got_data_q <= 1'b0;
            addr_q     <= 32'h0000_0000;
            miso       <= 1'b0;
            miso_oe    <= 1'b0;
        end else if (cs_s) begin
            state_q    <= S_OP;
            bit_cnt_q  <= 3'h0;
            addr_cnt_q <= 2'h0;
            miso_oe    <= 1'b0;
            miso       <= 1'b0;
            if (cs_rise) begin
                got_data_q <= 1'b0;
            end
        end else begin
            if (sclk_rise) begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                shift_q   <= byte_in[6:0];
            end
            if (sclk_fall && state_q == S_RD) begin
                miso    <= tx_q[7];
                miso_oe <= 1'b1;
                tx_q    <= {tx_q[6:0], 1'b0};
            end
            if (byte_done) begin
                case (state_q)
                    S_OP: begin
                        cmd_q <= byte_in;
                        case (byte_in)
                            `OP_RDSR: begin
                                state_q <= S_RD;
                                tx_q    <= status;
                            end
                            `OP_WRSR: begin
                                state_q <= S_DATA;
                            end
                            `OP_PROG, `OP_SECT_ERASE: begin
                                state_q <= S_ADDR;
                            end
                            default: begin
                                state_q <= S_IGN;
                            end
                        endcase
                    end
                    S_ADDR: begin
                        addr_q     <= {addr_q[23:0], byte_in};
                        addr_cnt_q <= addr_cnt_q + 2'h1;
                        if (addr_cnt_q == 2'h3) begin
                            state_q <= (cmd_q == `OP_PROG) ? S_DATA : S_IGN;
                        end
                    end
                    S_DATA: begin
                        if (!got_data_q) begin
                            wdata_q <= byte_in;
                        end
                        got_data_q <= 1'b1;
                    end
                    S_RD: begin
                        // Continuous read shows live busy on every byte
                        tx_q <= status;
                    end
                    S_IGN: begin
                        state_q <= S_IGN;
                    end
                    default: begin
                        state_q <= S_IGN;
                    end
                endcase
            end
        end
    end

    // Command execution at frame end and the busy timer
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status     <= `SR_RESET;
            flag_ready <= 1'b1;
            busy_cnt_q <= 16'h0000;
            array_req  <= 1'b0;
            array_cmd  <= 2'h0;
            array_addr <= {`ADDR_BITS{1'b0}};
            prot_err   <= 1'b0;
        end else begin
            array_req <= 1'b0;
            prot_err  <= 1'b0;
            if (status[`SR_BUSY_BIT]) begin
                if (busy_cnt_q == 16'h0001) begin
                    status[`SR_BUSY_BIT] <= 1'b0;
                    flag_ready           <= 1'b1;
                    status[`SR_WEL_BIT]  <= 1'b0;
                end
                busy_cnt_q <= busy_cnt_q - 16'h0001;
            end else if (cs_rise && bit_cnt_q == 3'h0) begin
                case (cmd_q)
                    `OP_WREN: begin
                        status[`SR_WEL_BIT] <= 1'b1;
                    end
                    `OP_WRDI: begin
                        status[`SR_WEL_BIT] <= 1'b0;
                    end
                    `OP_WRSR: begin
                        if (got_data_q && status[`SR_WEL_BIT]
                                && !hw_locked) begin
                            status <= (wdata_q & `SR_NV_MASK)
                                      | 8'h03;
                            flag_ready <= 1'b0;
                            busy_cnt_q <= WRSR_CYC[15:0];
                        end
                    end
                    `OP_PROG, `OP_SECT_ERASE: begin
                        // A frame cut inside the address is dropped
                        if (status[`SR_WEL_BIT] && state_q != S_ADDR
                                && (got_data_q
                                || cmd_q == `OP_SECT_ERASE)) begin
                            if (sect_hit) begin
                                prot_err <= 1'b1;
                            end else begin
                                status[`SR_BUSY_BIT] <= 1'b1;
                                flag_ready <= 1'b0;
                                array_req  <= 1'b1;
                                array_addr <= addr_q[`ADDR_BITS-1:0];
                                if (cmd_q == `OP_PROG) begin
                                    array_cmd  <= `ACMD_PROG;
                                    busy_cnt_q <= PROG_CYC[15:0];
                                end else begin
                                    array_cmd  <= `ACMD_SECT_ERASE;
                                    busy_cnt_q <= SERA_CYC[15:0];
                                end
                            end
                        end
                    end
                    `OP_DIE_ERASE: begin
                        if (status[`SR_WEL_BIT]) begin
                            if (prot_code != 4'h0) begin
                                prot_err <= 1'b1;
                            end else begin
                                status[`SR_BUSY_BIT] <= 1'b1;
                                flag_ready <= 1'b0;
                                array_req  <= 1'b1;
                                array_cmd  <= `ACMD_DIE_ERASE;
                                array_addr <= {`ADDR_BITS{1'b0}};
                                busy_cnt_q <= DERA_CYC[15:0];
                            end
                        end
                    end
                    default: begin
                        busy_cnt_q <= 16'h0000;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/flash_host_model.sv
// Behavioural host driving single-bit mode 0 serial frames into one die
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    input  wire logic clk,
    input  wire logic miso,
    output var  logic sclk,
    output var  logic cs_b,
    output var  logic mosi
);
    logic [7:0] rd_byte;
    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        mosi = 1'b0;
        rd_byte = 8'h00;
    end
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // Clock idles low between frames; data flips so a stale bit is never reused
    task automatic frame(input int n, input logic [47:0] d);
        int i;
        half();
        cs_b = 1'b0;
        for (i = 0; i < n * 8; i++) begin
            mosi = d[47 - i];
            half();
            sclk = 1'b1;
            rd_byte = {rd_byte[6:0], miso};
            half();
            sclk = 1'b0;
        end
        half();
        cs_b = 1'b1;
        mosi = ~mosi;
        repeat (6) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: tb/flash_status_block_protect_tb_top.sv
// Self-checking bench for the status and block protection logic of one die
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.vh"
module flash_status_block_protect_tb_top;
    typedef struct {
        logic       tb;
        logic [3:0] code;
        logic [9:0] sec;
        logic       prot;
    } row_t;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    logic                  wp_b = 1'b1;
    wire                   sclk, cs_b, mosi, miso, miso_oe;
    wire                   flag_ready, array_req, prot_err;
    wire [7:0]             status;
    wire [1:0]             array_cmd;
    wire [`ADDR_BITS-1:0]  array_addr;
    // No pull on the line: an undriven output shows the inverse bit
    wire                   miso_bus = miso_oe ? miso : ~miso;
    int                    error_cnt = 0;
    int                    n_compared = 0;
    int                    cyc = 0;
    int                    req_n = 0;
    int                    err_n = 0;
    int                    i, r0, e0;
    row_t rows [11] = '{'{1'b0, 4'h0, 10'h3FF, 1'b0}, '{1'b0, 4'h1, 10'h3FF, 1'b1},
        '{1'b0, 4'h1, 10'h3FE, 1'b0}, '{1'b0, 4'hA, 10'h200, 1'b1},
        '{1'b0, 4'hA, 10'h1FF, 1'b0}, '{1'b1, 4'h1, 10'h000, 1'b1},
        '{1'b1, 4'h1, 10'h001, 1'b0}, '{1'b1, 4'hA, 10'h1FF, 1'b1},
        '{1'b1, 4'hA, 10'h200, 1'b0}, '{1'b0, 4'hB, 10'h000, 1'b1},
        '{1'b1, 4'hF, 10'h3FF, 1'b1}};
    flash_host_model u_flash_host_model (.clk(clk), .miso(miso_bus),
        .sclk(sclk), .cs_b(cs_b), .mosi(mosi));
    // Long die erase so the busy window outlasts the frame tail
    status_protect_core #(.WRSR_CYC(4), .PROG_CYC(4), .SERA_CYC(4),
        .DERA_CYC(40)) u_status_protect_core (.clk(clk), .rst_b(rst_b),
        .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .wp_b(wp_b), .miso(miso),
        .miso_oe(miso_oe), .status(status), .flag_ready(flag_ready),
        .array_req(array_req), .array_cmd(array_cmd),
        .array_addr(array_addr), .prot_err(prot_err));
    always #25 clk = ~clk;
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (array_req === 1'b1) req_n++;
        if (prot_err === 1'b1) err_n++;
        if (cyc == 30000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_ready();
        int k;
        for (k = 0; k < 400 && status[0] !== 1'b0; k++) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input int n, input logic [47:0] d);
        u_flash_host_model.frame(n, d);
        wait_ready();
    endtask
    task automatic wrsr(input logic [7:0] v);
        cmd(1, {`OP_WREN, 40'h0});
        cmd(2, {`OP_WRSR, v, 32'h0});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst_b = 1'b1;
        check("status", status, 8'h00);
        check("ready", {miso_oe, flag_ready}, 2'h1);
        for (i = 0; i < 11; i++) begin
            wrsr({1'b0, rows[i].code[3], rows[i].tb, rows[i].code[2:0], 2'b00});
            cmd(2, {`OP_RDSR, 40'h0});
            check("read status", u_flash_host_model.rd_byte,
                {1'b0, rows[i].code[3], rows[i].tb, rows[i].code[2:0],
                2'b00});
            cmd(1, {`OP_WREN, 40'h0});
            r0 = req_n;
            e0 = err_n;
            cmd(5, {`OP_SECT_ERASE, 6'h00, rows[i].sec, 16'h0000, 8'h00});
            check("prot_err", err_n - e0, rows[i].prot);
            check("array_req", req_n - r0, !rows[i].prot);
            check("latch", status[1], rows[i].prot);
            if (!rows[i].prot)
                check("addr", {array_cmd, array_addr},
                    {`ACMD_SECT_ERASE, rows[i].sec, 16'h0000});
        end
        cmd(1, {`OP_WRDI, 40'h0});
        cmd(2, {`OP_WRSR, 8'h00, 32'h0});
        check("no latch write", status, 8'h7C);
        cmd(1, {`OP_WREN, 40'h0});
        e0 = err_n;
        cmd(1, {`OP_DIE_ERASE, 40'h0});
        check("die refused", err_n - e0, 1);
        wrsr(8'h80);
        wp_b = 1'b0;
        wrsr(8'h00);
        check("frozen", status[7:2], 6'h20);
        wp_b = 1'b1;
        wrsr(8'h00);
        check("unfrozen", status, 8'h00);
        cmd(1, {`OP_WREN, 40'h0});
        r0 = req_n;
        u_flash_host_model.frame(1, {`OP_DIE_ERASE, 40'h0});
        check("busy", {status[0], flag_ready}, 2'h2);
        wait_ready();
        check("die run", req_n - r0, 1);
        check("die cmd", {array_cmd, array_addr}, {`ACMD_DIE_ERASE, 26'h0});
        cmd(1, {`OP_WREN, 40'h0});
        r0 = req_n;
        cmd(3, {`OP_SECT_ERASE, 40'h0});
        check("cut frame", req_n - r0, 0);
        check("cut latch", status[1], 1'b1);
        cmd(1, {`OP_WREN, 40'h0});
        cmd(6, {`OP_PROG, 32'h03FF0010, 8'hA5});
        check("prog", {array_cmd, array_addr}, {`ACMD_PROG, 26'h3FF0010});
        cmd(1, {`OP_WREN, 40'h0});
        check("latch set", status[1], 1'b1);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        check("reset", {status, flag_ready, miso_oe}, 10'h002);
        end_of_test();
    end
endmodule
`default_nettype wire

// file: tb/status_protect_core_properties.sv
// Port assertions for the status and block protection logic of one die
`timescale 1ns/1ps
`default_nettype none
`include "status_protect_consts.vh"
module status_protect_core_properties (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       cs_b,
    input wire logic       wp_b,
    input wire logic       miso_oe,
    input wire logic [7:0] status,
    input wire logic       flag_ready,
    input wire logic       array_req,
    input wire logic [1:0] array_cmd,
    input wire logic       prot_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    AST_FLAG_INV: assert property (flag_ready == !status[0])
        else $error("ready flag differs from inverse of busy");
    AST_BUSY_ON_REQ: assert property (array_req |-> ##[0:1] status[0])
        else $error("array start without busy");
    AST_REQ_NEEDS_WEL: assert property (array_req |-> $past(status[1]))
        else $error("array start without write enable latch");
    AST_ERR_NO_REQ: assert property (prot_err |-> !array_req && status[1])
        else $error("refused operation started or dropped latch");
    AST_DIE_ERASE_BP: assert property (array_req && array_cmd == `ACMD_DIE_ERASE
        |-> {status[6], status[4:2]} == 4'h0)
        else $error("die erase ran with block protect set");
    AST_FROZEN: assert property (!wp_b [*4] ##0 status[7]
        |=> $stable(status[7:2]))
        else $error("protected status bits changed with pin low");
    AST_BUSY_END_WEL: assert property ($fell(status[0]) |-> !status[1])
        else $error("latch still set after operation end");
    AST_OE_IDLE: assert property (cs_b [*5] |-> !miso_oe)
        else $error("serial output driven while deselected");
endmodule
bind status_protect_core status_protect_core_properties u_props (
    .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .wp_b(wp_b), .miso_oe(miso_oe),
    .status(status), .flag_ready(flag_ready), .array_req(array_req),
    .array_cmd(array_cmd), .prot_err(prot_err));
`default_nettype wire
